// >>> hdl/mbhp_pkg.sv
`default_nettype none
package mbhp_pkg;
  // ----------------------------------------
  // Shared bus and extended control layout
  // ----------------------------------------
  localparam int BUS_W = 8;
  localparam logic [7:0] EXT_CTRL_ADDR = 8'h4B;
  localparam logic [2:0] POWER_CTRL_BIT = 3'h0;
  localparam logic [2:0] XTAL_SEL_BIT = 3'h1;
  localparam logic [1:0] EXT_CTRL_RST = 2'h0;

  // ----------------------------------------
  // Synchroniser bundle layout
  // ----------------------------------------
  localparam int SYNC_W = 14;
  localparam int SY_ALE = 8;
  localparam int SY_CS_N = 9;
  localparam int SY_RD_N = 10;
  localparam int SY_WR_N = 11;
  localparam int SY_KICK_N = 12;
  localparam int SY_VCC = 13;
  // Idle pin levels: strobes inactive, supply absent
  localparam logic [SYNC_W-1:0] SYNC_RST = 14'h1E00;
endpackage
`default_nettype wire

// >>> hdl/mbhp_sync_if.sv
`default_nettype none
interface mbhp_sync_if;
  import mbhp_pkg::*;
  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] clean;
  modport syncer (input raw, output clean);
  modport user (output raw, input clean);
endinterface
`default_nettype wire

// >>> hdl/mbhp_pin_sync.sv
`default_nettype none
module mbhp_pin_sync
  import mbhp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  mbhp_sync_if.syncer pins
);
  logic [SYNC_W-1:0] s1_ff;
  logic [SYNC_W-1:0] s2_ff;
  logic [SYNC_W-1:0] s3_ff;
  logic [SYNC_W-1:0] stable_ff;

  // ----------------------------------------
  // Three stages per pin, change on agreement
  // ----------------------------------------
  for (genvar i = 0; i < SYNC_W; i++) begin : g_bit
    wire logic agree = (s2_ff[i] == s3_ff[i]);
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        s1_ff[i] <= SYNC_RST[i];
        s2_ff[i] <= SYNC_RST[i];
        s3_ff[i] <= SYNC_RST[i];
        stable_ff[i] <= SYNC_RST[i];
      end else begin
        s1_ff[i] <= pins.raw[i];
        s2_ff[i] <= s1_ff[i];
        s3_ff[i] <= s2_ff[i];
        stable_ff[i] <= agree ? s3_ff[i] : stable_ff[i];
      end
    end
  end

  assign pins.clean = stable_ff;
endmodule
`default_nettype wire

// >>> hdl/mbhp_port.sv
`default_nettype none
// Summary of operation
// - Same eight pins carry address then data
// - Address valid before strobe end, captured there
// - Read drives one byte during read strobe
// - Bus released when read strobe rises
// - Extended RAM shares the same data path
// - Power-on output active low, open drain
// - No supply: kickstart or alarm asserts power
// - Powered: software power bit steers power output
// - Crystal load select bit, 6 or 12.5pF
// - Chip select gates transfers, not address latch
// - Address latched on strobe falling edge
// - Output buffers enabled only during read
module mbhp_port
  import mbhp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ale,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [BUS_W-1:0] shared_addr_data_bus_i,
  output logic [BUS_W-1:0] shared_addr_data_bus_o,
  output logic shared_addr_data_bus_oe,
  input wire logic kickstart_in_n,
  input wire logic vcc_present,
  input wire logic wakeup_alarm_irq,
  output logic power_on_request_n_o,
  output logic power_on_request_n_oe,
  output logic xtal_load_12p5,
  output logic [BUS_W-1:0] reg_addr,
  output logic [BUS_W-1:0] reg_wdata,
  output logic reg_wr_stb,
  output logic reg_rd_stb,
  input wire logic [BUS_W-1:0] reg_rdata
);
  mbhp_sync_if sy ();

  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------
  assign sy.raw = {vcc_present, kickstart_in_n, wr_n, rd_n, cs_n, ale,
                   shared_addr_data_bus_i};

  mbhp_pin_sync u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pins(sy)
  );

  wire logic [BUS_W-1:0] bus_c = sy.clean[BUS_W-1:0];
  wire logic ale_c = sy.clean[SY_ALE];
  wire logic cs_n_c = sy.clean[SY_CS_N];
  wire logic rd_n_c = sy.clean[SY_RD_N];
  wire logic wr_n_c = sy.clean[SY_WR_N];
  wire logic kick_n_c = sy.clean[SY_KICK_N];
  wire logic vcc_c = sy.clean[SY_VCC];

  // ----------------------------------------
  // Strobe edges and decode
  // ----------------------------------------
  logic ale_prev_ff;
  logic rd_n_prev_ff;
  logic wr_n_prev_ff;
  logic [BUS_W-1:0] addr_ff;
  logic [1:0] ext_ff;

  wire logic ale_fall = ale_prev_ff & ~ale_c;
  wire logic rd_fall = rd_n_prev_ff & ~rd_n_c;
  wire logic wr_rise = ~wr_n_prev_ff & wr_n_c;
  // Without chip select the cycle moves no data
  wire logic rd_start = rd_fall & ~cs_n_c;
  wire logic wr_done = wr_rise & ~cs_n_c;
  wire logic rd_active = ~rd_n_c & ~cs_n_c;
  wire logic ext_hit = (addr_ff == EXT_CTRL_ADDR);
  wire logic wr_ext = wr_done & ext_hit;
  wire logic auto_evt = ~vcc_c & (~kick_n_c | wakeup_alarm_irq);
  // Control bank readback; everything else is clock regs or RAM
  wire logic [BUS_W-1:0] ext_rdata = {6'h00, ext_ff};
  wire logic [BUS_W-1:0] rdata_mux = ext_hit ? ext_rdata : reg_rdata;
  // Auto power-up wins over a software clear in the same cycle
  wire logic nxt_power = auto_evt | (wr_ext ? bus_c[POWER_CTRL_BIT] : ext_ff[0]);
  wire logic nxt_xtal = wr_ext ? bus_c[XTAL_SEL_BIT] : ext_ff[1];

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ale_prev_ff <= 1'b0;
      rd_n_prev_ff <= 1'b1;
      wr_n_prev_ff <= 1'b1;
    end else begin
      ale_prev_ff <= ale_c;
      rd_n_prev_ff <= rd_n_c;
      wr_n_prev_ff <= wr_n_c;
    end
  end

  // ----------------------------------------
  // Address phase
  // ----------------------------------------
  // Latched even without chip select; held until the next strobe
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      addr_ff <= 8'h00;
    end else if (ale_fall) begin
      addr_ff <= bus_c;
    end
  end

  // ----------------------------------------
  // Data phase
  // ----------------------------------------
  logic [BUS_W-1:0] wdata_ff;
  logic wr_stb_ff;
  logic rd_stb_ff;
  logic [BUS_W-1:0] dout_ff;
  logic oe_ff;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wdata_ff <= 8'h00;
      wr_stb_ff <= 1'b0;
      rd_stb_ff <= 1'b0;
    end else begin
      wr_stb_ff <= wr_done;
      rd_stb_ff <= rd_start;
      if (wr_done) begin
        wdata_ff <= bus_c;
      end
    end
  end

  // Data is fetched once at strobe start so it stays stable to the end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dout_ff <= 8'h00;
      oe_ff <= 1'b0;
    end else begin
      oe_ff <= rd_active;
      if (rd_start) begin
        dout_ff <= rdata_mux;
      end
    end
  end

  // ----------------------------------------
  // Power-on and crystal control
  // ----------------------------------------
  logic power_drive_ff;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ext_ff <= EXT_CTRL_RST;
      power_drive_ff <= 1'b0;
    end else begin
      ext_ff <= {nxt_xtal, nxt_power};
      power_drive_ff <= nxt_power;
    end
  end

  assign shared_addr_data_bus_o = dout_ff;
  assign shared_addr_data_bus_oe = oe_ff;
  // Open drain: only ever pulls low, the enable carries the request
  assign power_on_request_n_o = 1'b0;
  assign power_on_request_n_oe = power_drive_ff;
  assign xtal_load_12p5 = ext_ff[1];
  assign reg_addr = addr_ff;
  assign reg_wdata = wdata_ff;
  assign reg_wr_stb = wr_stb_ff;
  assign reg_rd_stb = rd_stb_ff;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_addr_latch;
    @(posedge clk_sys) disable iff (!rst_n)
    ale_fall |=> (reg_addr == $past(bus_c));
  endproperty
  a_addr_latch: assert property (p_addr_latch) else $error("address not latched");

  property p_addr_hold;
    @(posedge clk_sys) disable iff (!rst_n)
    !ale_fall |=> $stable(reg_addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address changed");

  property p_read_drive;
    @(posedge clk_sys) disable iff (!rst_n)
    rd_start |=> shared_addr_data_bus_oe && reg_rd_stb
      && (shared_addr_data_bus_o == $past(rdata_mux));
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read byte missing");

  property p_release;
    @(posedge clk_sys) disable iff (!rst_n)
    rd_n_c |=> !shared_addr_data_bus_oe;
  endproperty
  a_release: assert property (p_release) else $error("bus not released");

  property p_oe_only_read;
    @(posedge clk_sys) disable iff (!rst_n)
    shared_addr_data_bus_oe |-> $past(rd_active);
  endproperty
  a_oe_only_read: assert property (p_oe_only_read) else $error("drive outside read");

  property p_write_capture;
    @(posedge clk_sys) disable iff (!rst_n)
    wr_done |=> reg_wr_stb && (reg_wdata == $past(bus_c)) ##1 !reg_wr_stb;
  endproperty
  a_write_capture: assert property (p_write_capture) else $error("write not taken");

  property p_no_cs_no_xfer;
    @(posedge clk_sys) disable iff (!rst_n)
    cs_n_c |=> !reg_wr_stb && !reg_rd_stb;
  endproperty
  a_no_cs_no_xfer: assert property (p_no_cs_no_xfer) else $error("transfer without cs");

  property p_auto_power;
    @(posedge clk_sys) disable iff (!rst_n)
    auto_evt |=> power_on_request_n_oe && !power_on_request_n_o;
  endproperty
  a_auto_power: assert property (p_auto_power) else $error("auto power-on missed");

  property p_sw_power;
    @(posedge clk_sys) disable iff (!rst_n)
    (wr_ext && !auto_evt) |=> (power_on_request_n_oe == $past(bus_c[POWER_CTRL_BIT]));
  endproperty
  a_sw_power: assert property (p_sw_power) else $error("software power ignored");

  property p_xtal_sel;
    @(posedge clk_sys) disable iff (!rst_n)
    wr_ext |=> (xtal_load_12p5 == $past(bus_c[XTAL_SEL_BIT]));
  endproperty
  a_xtal_sel: assert property (p_xtal_sel) else $error("crystal select not set");

  property p_od_low;
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(power_on_request_n_oe) |-> !power_on_request_n_o && $past(auto_evt || wr_ext);
  endproperty
  a_od_low: assert property (p_od_low) else $error("power pin driven high");

  c_read: cover property (@(posedge clk_sys) disable iff (!rst_n) rd_start ##1 reg_rd_stb);
  c_write_ext: cover property (@(posedge clk_sys) disable iff (!rst_n) wr_ext);
  c_kick: cover property (@(posedge clk_sys) disable iff (!rst_n) !vcc_c && !kick_n_c);
  c_alarm: cover property (@(posedge clk_sys) disable iff (!rst_n)
    !vcc_c && wakeup_alarm_irq);
endmodule
`default_nettype wire

// >>> sim/mbhp_host_model.sv
`default_nettype none
module mbhp_host_model (
  input wire logic clk_sys,
  input wire logic [7:0] dut_o,
  input wire logic dut_oe,
  output logic [7:0] bus,
  output logic ale,
  output logic cs_n,
  output logic rd_n,
  output logic wr_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv = 1'b0;
  logic [7:0] v = 8'h00;
  initial begin
    ale = 1'b0;
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
  end
  // Released bus shows the inverse byte so a stale value never matches
  assign bus = dut_oe ? dut_o : (drv ? v : ~v);
  // q is the bus level at the edge that ends the strobe
  task automatic cycle(input logic [7:0] a, input logic wr, input logic sel,
                       input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys);
    ale <= 1'b1;
    drv <= 1'b1;
    v <= a;
    repeat (4) @(posedge clk_sys);
    ale <= 1'b0;
    repeat (6) @(posedge clk_sys);
    cs_n <= ~sel;
    drv <= wr;
    v <= d;
    wr_n <= ~wr;
    rd_n <= wr;
    repeat (8) @(posedge clk_sys);
    q = bus;
    wr_n <= 1'b1;
    rd_n <= 1'b1;
    // Data and select held past the strobe end for the sync delay
    repeat (6) @(posedge clk_sys);
    cs_n <= 1'b1;
    drv <= 1'b0;
    repeat (8) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// >>> sim/mbhp_port_tb_top.sv
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end
module mbhp_port_tb_top
  import mbhp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic kick_n = 1'b1;
  logic vcc = 1'b1;
  logic alarm = 1'b0;
  wire logic [7:0] bus, bus_o, r_addr, r_wdata, r_rdata;
  wire logic oe, ale, cs_n, rd_n, wr_n, power_o, power_oe, xtal, wr_stb, rd_stb;
  int fail_count = 0;
  int compares = 0;
  int wr_cnt = 0;
  int rd_cnt = 0;
  logic [7:0] wd_seen = 8'h00;
  // Stand-in memory: each location reads as its inverted address
  assign r_rdata = ~r_addr;
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (wr_stb === 1'b1) wr_cnt++;
    if (wr_stb === 1'b1) wd_seen <= r_wdata;
    if (rd_stb === 1'b1) rd_cnt++;
  end
  mbhp_host_model u_host (.clk_sys(clk_sys), .dut_o(bus_o), .dut_oe(oe), .bus(bus),
    .ale(ale), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n));
  mbhp_port u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .ale(ale), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .shared_addr_data_bus_i(bus), .shared_addr_data_bus_o(bus_o),
    .shared_addr_data_bus_oe(oe), .kickstart_in_n(kick_n), .vcc_present(vcc),
    .wakeup_alarm_irq(alarm), .power_on_request_n_o(power_o),
    .power_on_request_n_oe(power_oe), .xtal_load_12p5(xtal), .reg_addr(r_addr),
    .reg_wdata(r_wdata), .reg_wr_stb(wr_stb), .reg_rd_stb(rd_stb), .reg_rdata(r_rdata));
  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic sel);
    logic [7:0] q;
    int n;
    n = wr_cnt;
    u_host.cycle(a, 1'b1, sel, d, q);
    `CHK(q, d)
    `CHK(wr_cnt - n, sel ? 1 : 0)
    `CHK(r_addr, a)
    if (sel) `CHK(wd_seen, d)
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic sel);
    logic [7:0] q;
    int n;
    n = rd_cnt;
    u_host.cycle(a, 1'b0, sel, 8'h00, q);
    `CHK(q, exp)
    `CHK(rd_cnt - n, sel ? 1 : 0)
    `CHK(oe, 1'b0)
  endtask
  task automatic power_wait(input logic exp);
    repeat (10) @(posedge clk_sys);
    `CHK(power_oe, exp)
    `CHK(power_o, 1'b0)
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_bus;
    wr(8'h4B, 8'h02, 1'b1);
    `CHK(xtal, 1'b1)
    rd(8'h4B, 8'h02, 1'b1);
    rd(8'h80, 8'h7F, 1'b1);
    wr(8'hF1, 8'hA5, 1'b1);
    // Other addresses must leave the control bits alone
    `CHK(power_oe, 1'b0)
    `CHK(xtal, 1'b1)
    rd(8'h0E, 8'hF1, 1'b1);
    wr(8'h4B, 8'h00, 1'b1);
    `CHK(xtal, 1'b0)
    $display("test bus done");
  endtask
  task automatic t_cs;
    wr(8'h4B, 8'h02, 1'b0);
    `CHK(xtal, 1'b0)
    rd(8'h44, 8'hFF, 1'b0);
    `CHK(r_addr, 8'h44)
    $display("test select done");
  endtask
  task automatic t_power;
    @(posedge clk_sys);
    kick_n <= 1'b0;
    power_wait(1'b0);
    vcc <= 1'b0;
    power_wait(1'b1);
    kick_n <= 1'b1;
    vcc <= 1'b1;
    power_wait(1'b1);
    wr(8'h4B, 8'h00, 1'b1);
    `CHK(power_oe, 1'b0)
    vcc <= 1'b0;
    repeat (8) @(posedge clk_sys);
    alarm <= 1'b1;
    @(posedge clk_sys);
    alarm <= 1'b0;
    vcc <= 1'b1;
    power_wait(1'b1);
    wr(8'h4B, 8'h00, 1'b1);
    wr(8'h4B, 8'h01, 1'b1);
    `CHK(power_oe, 1'b1)
    rd(8'h4B, 8'h01, 1'b1);
    wr(8'h4B, 8'h00, 1'b1);
    `CHK(power_oe, 1'b0)
    $display("test power done");
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    t_bus;
    t_cs;
    t_power;
    close_out;
  end
  // Whole run is near 490 cycles
  initial begin
    repeat (8000) @(posedge clk_sys);
    fail_count++;
    close_out;
  end
endmodule
`undef CHK
`default_nettype wire
